// ### dv/epv_upstream_model.sv
// upstream device that raises the shared error line after a set lag
`timescale 1ns/100ps
module epv_upstream_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // error command from the bench
    input wire logic i_raise,
    input wire logic [3:0] i_lag,
    // error line towards the device
    output logic o_fault_level
);
    logic [3:0] wait_reg;

    // lag 0 answers promptly, larger lags model a slow upstream part
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_reg <= 4'h0;
            o_fault_level <= 1'b0;
        end else if (!i_raise) begin
            wait_reg <= 4'h0;
            o_fault_level <= 1'b0;
        end else if (wait_reg >= i_lag) begin
            o_fault_level <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

// ### dv/error_pin_and_vcm_control_tb.sv
// self-checking bench for fault pin routing and common-mode control
`timescale 1ns/100ps
module error_pin_and_vcm_control_tb;
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    epv_pkg::epv_reg_req_t req = '0;
    logic crc_en = 1'b0;
    logic crc_clr = 1'b0;
    logic ovr = 1'b0;
    epv_pkg::epv_int_err_t ierr = '0;
    epv_pkg::epv_spi_err_t serr = '0;
    logic raise = 1'b0;
    logic [3:0] lag = 4'h0;
    logic fault_in, rvalid, crc_err, fpin, foe, pwrdn, srcsel;
    logic [7:0] rdata, rcrc;
    logic [4:0] rcode, num;
    int bad_count = 0;
    int tests_run = 0;

    always #5 i_ref_clk = ~i_ref_clk;

    epv_upstream_model upstream (.i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n), .i_raise(raise), .i_lag(lag),
        .o_fault_level(fault_in));

    epv_fault_cmbuf DUT (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_reg_req(req), .o_reg_rvalid(rvalid), .o_reg_rdata(rdata),
        .o_reg_rcrc(rcrc), .i_spi_crc_en(crc_en), .i_spi_crc_clr(crc_clr),
        .i_overrange_err(ovr), .i_int_err(ierr), .i_spi_err(serr),
        .o_spi_crc_err(crc_err), .i_fault_input_pin(fault_in),
        .o_fault_output_pin(fpin), .o_fault_output_oe(foe),
        .o_common_buffer_powerdown(pwrdn),
        .o_common_level_source_select(srcsel),
        .o_common_level_ratio_code(rcode),
        .o_common_level_numerator(num));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = epv_pkg::CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? epv_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    function automatic logic [4:0] exp_num(input logic [4:0] c);
        if (c >= 5'h02 && c <= 5'h0a) return 5'h15 - c;
        if (c >= 5'h0b && c <= 5'h13) return 5'h14 - c;
        return 5'h0a;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    task automatic pin(input logic e);
        check({7'h00, fpin}, {7'h00, e});
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d,
                             input logic bad);
        @(negedge i_ref_clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        req.wcrc = crc8({a, d}) ^ (bad ? 8'hff : 8'h00);
        @(negedge i_ref_clk);
        req.wr = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_ref_clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge i_ref_clk);
        req.rd = 1'b0;
        check({7'h00, rvalid}, 8'h01);
        check(rdata, e);
        check(rcrc, crc_en ? crc8({a, e}) : 8'h00);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #60000;
        bad_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        tick(4);
        i_reset_n = 1'b1;
        pin(1'b0);
        check({3'h0, num}, 8'h0a);
        reg_read(epv_pkg::ADDR_FAULT_SRC, epv_pkg::RST_FAULT_SRC);
        reg_read(epv_pkg::ADDR_FAULT_CTRL, epv_pkg::RST_FAULT_CTRL);
        reg_read(epv_pkg::ADDR_CMBUF, epv_pkg::RST_CMBUF);
        reg_read(8'h25, 8'h00);
        reg_write(epv_pkg::ADDR_FAULT_SRC, 8'hff, 1'b0);
        reg_read(epv_pkg::ADDR_FAULT_SRC, 8'h38);
        reg_write(epv_pkg::ADDR_FAULT_CTRL, 8'hff, 1'b0);
        reg_read(epv_pkg::ADDR_FAULT_CTRL, 8'h03);
        check({7'h00, foe}, 8'h01);
        $display("test reset and access done");

        // each source alone, first with its own enable clear
        ierr.det_en = 6'h01;
        for (int k = 0; k < 3; k++) begin
            reg_write(epv_pkg::ADDR_FAULT_SRC, 8'h38 & ~(8'h20 >> k), 1'b0);
            {ovr, ierr.flag[0], serr.rd_err} = 3'b100 >> k;
            tick(2);
            pin(1'b0);
            reg_write(epv_pkg::ADDR_FAULT_SRC, 8'h20 >> k, 1'b0);
            tick(1);
            pin(1'b1);
            {ovr, ierr.flag[0], serr.rd_err} = 3'b000;
            tick(2);
            pin(1'b0);
        end
        reg_write(epv_pkg::ADDR_FAULT_SRC, 8'h10, 1'b0);
        ierr = '{flag: 6'h3f, det_en: 6'h00};
        tick(2);
        pin(1'b0);
        for (int i = 0; i < 6; i++) begin
            ierr.det_en = 6'h01 << i;
            tick(2);
            pin(1'b1);
        end
        ierr = '0;
        reg_write(epv_pkg::ADDR_FAULT_SRC, 8'h08, 1'b0);
        for (int i = 0; i < 3; i++) begin
            serr = 3'b001 << i;
            tick(2);
            pin(1'b1);
        end
        serr = '0;
        ovr = 1'b1;
        reg_write(epv_pkg::ADDR_FAULT_SRC, 8'h20, 1'b0);
        reg_write(epv_pkg::ADDR_FAULT_CTRL, 8'h02, 1'b0);
        tick(2);
        pin(1'b0);
        check({7'h00, foe}, 8'h00);
        ovr = 1'b0;
        $display("test source routing done");

        // serial check word on writes and reads
        reg_write(epv_pkg::ADDR_FAULT_SRC, 8'h08, 1'b0);
        reg_write(epv_pkg::ADDR_FAULT_CTRL, 8'h01, 1'b0);
        reg_write(epv_pkg::ADDR_CMBUF, 8'h55, 1'b1);
        tick(2);
        pin(1'b0);
        crc_en = 1'b1;
        reg_write(epv_pkg::ADDR_CMBUF, 8'h2a, 1'b1);
        tick(1);
        check({7'h00, crc_err}, 8'h01);
        tick(1);
        pin(1'b1);
        reg_read(epv_pkg::ADDR_CMBUF, 8'h55);
        crc_clr = 1'b1;
        tick(1);
        crc_clr = 1'b0;
        tick(1);
        check({7'h00, crc_err}, 8'h00);
        crc_en = 1'b0;
        $display("test check word done");

        // daisy-chained input, enabled then disabled
        reg_write(epv_pkg::ADDR_FAULT_SRC, 8'h00, 1'b0);
        reg_write(epv_pkg::ADDR_FAULT_CTRL, 8'h03, 1'b0);
        lag = 4'h3;
        raise = 1'b1;
        tick(9);
        pin(1'b1);
        reg_read(epv_pkg::ADDR_FAULT_CTRL, 8'h07);
        raise = 1'b0;
        tick(6);
        pin(1'b0);
        reg_read(epv_pkg::ADDR_FAULT_CTRL, 8'h03);
        reg_write(epv_pkg::ADDR_FAULT_CTRL, 8'h01, 1'b0);
        lag = 4'h0;
        raise = 1'b1;
        tick(8);
        pin(1'b0);
        reg_read(epv_pkg::ADDR_FAULT_CTRL, 8'h01);
        raise = 1'b0;
        $display("test error input done");

        // every ratio code, then source select and power-down
        for (int c = 0; c < 32; c++) begin
            reg_write(epv_pkg::ADDR_CMBUF, {2'b00, 5'(c), 1'b0}, 1'b0);
            tick(1);
            check({3'h0, rcode}, 8'(c));
            check({3'h0, num}, {3'h0, exp_num(5'(c))});
        end
        reg_write(epv_pkg::ADDR_CMBUF, 8'h7f, 1'b0);
        tick(1);
        check({6'h00, pwrdn, srcsel}, 8'h03);
        check({3'h0, num}, 8'h0a);
        reg_write(epv_pkg::ADDR_CMBUF, 8'h04, 1'b0);
        tick(1);
        check({6'h00, pwrdn, srcsel}, 8'h00);
        check({3'h0, num}, 8'h13);
        $display("test common-mode control done");
        report_and_stop();
    end
endmodule

// ### hdl/epv_fault_cmbuf.sv
// fault pin routing, daisy-chain input and common-mode buffer control
`timescale 1ns/100ps
module epv_fault_cmbuf (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // register port from the serial host engine
    input wire epv_pkg::epv_reg_req_t i_reg_req,
    output logic o_reg_rvalid,
    output logic [7:0] o_reg_rdata,
    output logic [7:0] o_reg_rcrc,
    // diagnostic controls and error detectors
    input wire logic i_spi_crc_en,
    input wire logic i_spi_crc_clr,
    input wire logic i_overrange_err,
    input wire epv_pkg::epv_int_err_t i_int_err,
    input wire epv_pkg::epv_spi_err_t i_spi_err,
    output logic o_spi_crc_err,
    // fault pins
    input wire logic i_fault_input_pin,
    output logic o_fault_output_pin,
    output logic o_fault_output_oe,
    // common-mode buffer controls
    output logic o_common_buffer_powerdown,
    output logic o_common_level_source_select,
    output logic [4:0] o_common_level_ratio_code,
    output logic [4:0] o_common_level_numerator
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        logic fb;
        c = epv_pkg::CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0} ^ (fb ? epv_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // ratio code to numerator over twenty
    function automatic logic [4:0] ratio_num(input logic [4:0] code);
        logic [4:0] n;
        n = epv_pkg::NUM_HALF;
        if (code >= epv_pkg::RATIO_HI_FIRST &&
            code <= epv_pkg::RATIO_HI_LAST) begin
            n = 5'(epv_pkg::NUM_HI_TOP - code);
        end else if (code >= epv_pkg::RATIO_LO_FIRST &&
            code <= epv_pkg::RATIO_LO_LAST) begin
            n = 5'(epv_pkg::NUM_LO_TOP - code);
        end
        return n;
    endfunction

    // ------------------------------------------------------------
    // input pin synchroniser
    // ------------------------------------------------------------
    logic fault_in_sync;

    epv_sync u_fault_in_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_fault_input_pin),
        .o_sync(fault_in_sync)
    );

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] src_reg;
    logic [7:0] src_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] cmb_reg;
    logic [7:0] cmb_next;
    logic crc_flag_reg;
    logic crc_flag_next;
    logic crc_bad;
    logic wr_ok;
    logic [7:0] rd_mux;

    always_comb begin
        src_next = src_reg;
        ctrl_next = ctrl_reg;
        cmb_next = cmb_reg;
        crc_bad = i_spi_crc_en && i_reg_req.wr &&
            (crc8({i_reg_req.addr, i_reg_req.wdata}) != i_reg_req.wcrc);
        // with checking on, a write with a bad check word is dropped
        wr_ok = i_reg_req.wr && !crc_bad;
        if (wr_ok) begin
            case (i_reg_req.addr)
                epv_pkg::ADDR_FAULT_SRC: begin
                    src_next = i_reg_req.wdata & epv_pkg::MASK_FAULT_SRC;
                end
                epv_pkg::ADDR_FAULT_CTRL: begin
                    ctrl_next = i_reg_req.wdata & epv_pkg::MASK_FAULT_CTRL;
                end
                epv_pkg::ADDR_CMBUF: begin
                    cmb_next = i_reg_req.wdata & epv_pkg::MASK_CMBUF;
                end
                default: begin
                end
            endcase
        end
        // set wins over clear
        crc_flag_next = crc_bad || (crc_flag_reg && !i_spi_crc_clr);
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            src_reg <= epv_pkg::RST_FAULT_SRC;
            ctrl_reg <= epv_pkg::RST_FAULT_CTRL;
            cmb_reg <= epv_pkg::RST_CMBUF;
            crc_flag_reg <= 1'b0;
        end else begin
            src_reg <= src_next;
            ctrl_reg <= ctrl_next;
            cmb_reg <= cmb_next;
            crc_flag_reg <= crc_flag_next;
        end
    end

    // ------------------------------------------------------------
    // fault input latch and fault output
    // ------------------------------------------------------------
    logic in_latch_reg;
    logic in_latch_next;
    logic fault_reg;
    logic fault_next;
    logic oe_reg;
    logic oe_next;
    logic int_active;
    logic spi_active;

    always_comb begin
        in_latch_next = ctrl_reg[epv_pkg::CTRL_IN_EN_BIT] && fault_in_sync;
        int_active = |(i_int_err.flag & i_int_err.det_en);
        spi_active = i_spi_err.rd_err || i_spi_err.wr_err ||
            i_spi_err.sclk_err || crc_flag_reg;
        fault_next = ctrl_reg[epv_pkg::CTRL_OUT_EN_BIT] && (
            (src_reg[epv_pkg::SRC_OVR_BIT] && i_overrange_err) ||
            (src_reg[epv_pkg::SRC_INT_BIT] && int_active) ||
            (src_reg[epv_pkg::SRC_SPI_BIT] && spi_active) ||
            (ctrl_reg[epv_pkg::CTRL_IN_EN_BIT] && in_latch_reg));
        oe_next = ctrl_reg[epv_pkg::CTRL_OUT_EN_BIT];
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            in_latch_reg <= 1'b0;
            fault_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            in_latch_reg <= in_latch_next;
            fault_reg <= fault_next;
            oe_reg <= oe_next;
        end
    end

    // ------------------------------------------------------------
    // read path with appended check word
    // ------------------------------------------------------------
    logic rvalid_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] rcrc_reg;
    logic [7:0] rcrc_next;

    always_comb begin
        case (i_reg_req.addr)
            epv_pkg::ADDR_FAULT_SRC: begin
                rd_mux = src_reg;
            end
            epv_pkg::ADDR_FAULT_CTRL: begin
                rd_mux = ctrl_reg;
                rd_mux[epv_pkg::CTRL_IN_STATUS_BIT] = in_latch_reg;
            end
            epv_pkg::ADDR_CMBUF: begin
                rd_mux = cmb_reg;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
        rdata_next = i_reg_req.rd ? rd_mux : 8'h00;
        rcrc_next = (i_reg_req.rd && i_spi_crc_en) ?
            crc8({i_reg_req.addr, rd_mux}) : 8'h00;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rcrc_reg <= 8'h00;
        end else begin
            rvalid_reg <= i_reg_req.rd;
            rdata_reg <= rdata_next;
            rcrc_reg <= rcrc_next;
        end
    end

    // ------------------------------------------------------------
    // common-mode buffer outputs
    // ------------------------------------------------------------
    logic pd_reg;
    logic sel_reg;
    logic [4:0] code_reg;
    logic [4:0] num_reg;
    logic [4:0] num_next;

    always_comb begin
        // half supply ignores the ratio field
        num_next = cmb_reg[epv_pkg::CMB_SRC_BIT] ? epv_pkg::NUM_HALF :
            ratio_num(cmb_reg[epv_pkg::CMB_RATIO_MSB:
                epv_pkg::CMB_RATIO_LSB]);
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pd_reg <= 1'b0;
            sel_reg <= 1'b0;
            code_reg <= epv_pkg::RATIO_HALF_CODE;
            num_reg <= epv_pkg::NUM_HALF;
        end else begin
            pd_reg <= cmb_reg[epv_pkg::CMB_PWRDN_BIT];
            sel_reg <= cmb_reg[epv_pkg::CMB_SRC_BIT];
            code_reg <= cmb_reg[epv_pkg::CMB_RATIO_MSB:
                epv_pkg::CMB_RATIO_LSB];
            num_reg <= num_next;
        end
    end

    assign o_reg_rvalid = rvalid_reg;
    assign o_reg_rdata = rdata_reg;
    assign o_reg_rcrc = rcrc_reg;
    assign o_spi_crc_err = crc_flag_reg;
    assign o_fault_output_pin = fault_reg;
    assign o_fault_output_oe = oe_reg;
    assign o_common_buffer_powerdown = pd_reg;
    assign o_common_level_source_select = sel_reg;
    assign o_common_level_ratio_code = code_reg;
    assign o_common_level_numerator = num_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence cmb_write_s;
        wr_ok && i_reg_req.addr == epv_pkg::ADDR_CMBUF;
    endsequence

    overrange_route_a: assert property (
        ctrl_reg[0] && src_reg[5] && i_overrange_err |=> fault_reg)
        else $error("overrange not reported");
    internal_route_a: assert property (
        ctrl_reg[0] && src_reg[4] && int_active |=> fault_reg)
        else $error("internal error not reported");
    detector_gate_a: assert property (
        ctrl_reg[1:0] == 2'b01 && src_reg == 8'h10 &&
        (i_int_err.flag & i_int_err.det_en) == '0 |=> !fault_reg)
        else $error("disabled detector drove pin");
    spi_route_a: assert property (
        ctrl_reg[0] && src_reg[3] && i_spi_err.wr_err |=> fault_reg)
        else $error("serial error not reported");
    crc_quiet_a: assert property (
        !i_spi_crc_en && !crc_flag_reg |=> !crc_flag_reg)
        else $error("crc flag set while checking off");
    status_read_a: assert property (
        i_reg_req.rd && i_reg_req.addr == epv_pkg::ADDR_FAULT_CTRL
        |=> rvalid_reg && rdata_reg[2] == $past(in_latch_reg))
        else $error("input status readback wrong");
    chain_in_a: assert property (
        ctrl_reg[1:0] == 2'b11 && in_latch_reg |=> fault_reg)
        else $error("chained input not forwarded");
    out_disable_a: assert property (
        !ctrl_reg[0] |=> !fault_reg && !oe_reg)
        else $error("fault pin active while disabled");
    powerdown_ctl_a: assert property (
        cmb_write_s |=> ##1 pd_reg == $past(i_reg_req.wdata[6], 2))
        else $error("powerdown not applied");
    ratio_map_a: assert property (
        cmb_write_s ##1 !cmb_reg[0] |=>
        num_reg == ratio_num($past(cmb_reg[5:1])))
        else $error("ratio numerator wrong");
    ratio_ends_a: assert property (
        !cmb_reg[0] && cmb_reg[5:1] == 5'h02 |=> num_reg == 5'h13)
        else $error("first ratio code not nineteen twentieths");
    half_supply_a: assert property (
        cmb_write_s ##1 cmb_reg[0] |=> sel_reg && num_reg == 5'h0a)
        else $error("half supply select wrong");
    crc_flag_a: assert property (
        crc_bad |=> crc_flag_reg ##0 $stable(src_reg))
        else $error("bad check word not flagged");
    pin_cause_a: assert property (
        fault_reg |-> $past(ctrl_reg[0]) && $past(fault_next))
        else $error("fault pin without cause");
    reserved_ratio_a: assert property (
        !cmb_reg[0] && cmb_reg[5:1] >= 5'h14 && cmb_reg[5:1] <= 5'h1c
        |=> num_reg == 5'h0a)
        else $error("reserved ratio not half level");

endmodule

// ### hdl/epv_pkg.sv
// constants and carrier types for the fault pin and common-mode control
package epv_pkg;

    // ------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FAULT_SRC = 8'h22;
    localparam logic [7:0] ADDR_FAULT_CTRL = 8'h23;
    localparam logic [7:0] ADDR_CMBUF = 8'h24;
    localparam logic [7:0] RST_FAULT_SRC = 8'h00;
    localparam logic [7:0] RST_FAULT_CTRL = 8'h00;
    localparam logic [7:0] RST_CMBUF = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SRC_OVR_BIT = 5;
    localparam int SRC_INT_BIT = 4;
    localparam int SRC_SPI_BIT = 3;
    localparam int CTRL_IN_STATUS_BIT = 2;
    localparam int CTRL_IN_EN_BIT = 1;
    localparam int CTRL_OUT_EN_BIT = 0;
    localparam int CMB_PWRDN_BIT = 6;
    localparam int CMB_RATIO_MSB = 5;
    localparam int CMB_RATIO_LSB = 1;
    localparam int CMB_SRC_BIT = 0;

    // writable bits of each register
    localparam logic [7:0] MASK_FAULT_SRC = 8'h38;
    localparam logic [7:0] MASK_FAULT_CTRL = 8'h03;
    localparam logic [7:0] MASK_CMBUF = 8'h7f;

    // ------------------------------------------------------------
    // ratio codes, numerator in twentieths of the reference
    // ------------------------------------------------------------
    localparam logic [4:0] RATIO_HALF_CODE = 5'h00;
    localparam logic [4:0] RATIO_HI_FIRST = 5'h02;
    localparam logic [4:0] RATIO_HI_LAST = 5'h0a;
    localparam logic [4:0] RATIO_LO_FIRST = 5'h0b;
    localparam logic [4:0] RATIO_LO_LAST = 5'h13;
    localparam logic [4:0] NUM_HALF = 5'h0a;
    localparam logic [4:0] NUM_HI_TOP = 5'h15;
    localparam logic [4:0] NUM_LO_TOP = 5'h14;

    // ------------------------------------------------------------
    // serial link check word
    // ------------------------------------------------------------
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam int N_INT_ERR = 6;

    // internal error sources and their detector enables
    typedef struct packed {
        logic [N_INT_ERR-1:0] flag;
        logic [N_INT_ERR-1:0] det_en;
    } epv_int_err_t;

    // serial-interface error flags from the host port
    typedef struct packed {
        logic rd_err;
        logic wr_err;
        logic sclk_err;
    } epv_spi_err_t;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] wcrc;
    } epv_reg_req_t;

endpackage

// ### hdl/epv_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module epv_sync (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // level in and out
    input wire logic i_async,
    output logic o_sync
);

    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;

endmodule
